// File: rtl/cfm_clock_failure_monitor.sv
// Notes on behaviour
// - Detectors may be re-enabled any time after the source select write completes.
// - Internal precision oscillator runs after reset; only software turns it off.
// - Primary failure raises an event and routes the watchdog oscillator to system clock.
// - Fallback happens only while the watchdog oscillator is enabled.
// - No fallback when the watchdog oscillator is itself the selected source.
// - Primary failure flagged when system clock drops below about 1 kHz.
// - Watchdog oscillator failure raises an event, clock source unchanged.
// - After a watchdog oscillator failure, primary failures are no longer detected.
// - Watchdog oscillator failure after 8004 system clocks without its edge.
// - After fallback the CPU keeps running from the slow clock.
`timescale 1ns/1ps
`include "cfm_map.svh"

module cfm_clock_failure_monitor
  import cfm_pkg::*;
#(
  parameter int PRI_FAIL_CYCLES = `CFM_PRI_FAIL_CYCLES,
  parameter int WDT_FAIL_EDGES = `CFM_WDT_FAIL_EDGES
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [`CFM_NUM_SRC-1:0] osc_in,
  input wire cfm_oscillator_control_t ctrl_in,
  input wire cfm_ack_t ack_in,
  output cfm_status_t status_out
);

  // ----------------------------------------------------------------
  // Oscillator edge capture
  // ----------------------------------------------------------------
  logic [`CFM_NUM_SRC-1:0] osc_rise;

  for (genvar i = 0; i < `CFM_NUM_SRC; i++)
  begin : g_sync
    cfm_edge_sync u_sync (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .ce_in(ce_in),
      .async_in(osc_in[i]),
      .rise_out(osc_rise[i])
    );
  end

  cfm_state_t st_q;
  cfm_state_t st_d;

  logic sys_edge;
  logic wdt_edge;
  logic pri_run;
  logic wdt_run;
  logic pri_expired;
  logic wdt_expired;
  logic sel_is_wdt;

  assign sys_edge = osc_rise[st_q.stat.sys_clk_select];
  assign wdt_edge = osc_rise[`CFM_SRC_WDT];
  assign sel_is_wdt = (st_q.stat.sys_clk_select == `CFM_SRC_WDT);

  // ----------------------------------------------------------------
  // Detector enables
  // ----------------------------------------------------------------
  // Primary watch is parked once the watchdog oscillator has died, and
  // while fallback already holds the clock.
  assign pri_run = ctrl_in.primary_fail_detect_en
                   & ~st_q.stat.wdt_failed
                   & (st_q.mode == CFM_RUN);

  // Watchdog watch cannot work off its own clock or a stopped oscillator.
  assign wdt_run = ctrl_in.wdt_osc_fail_detect_en
                   & ctrl_in.wdt_osc_en
                   & ~sel_is_wdt
                   & ~st_q.stat.wdt_failed;

  // ----------------------------------------------------------------
  // Primary clock watch: real-time window with no source edge
  // ----------------------------------------------------------------
  // Restart on a select write so the old source's gap is not charged
  // to the new one.
  cfm_watch #(
    .LIMIT(PRI_FAIL_CYCLES)
  ) u_pri_watch (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .run_in(pri_run),
    .tick_in(1'b1),
    .restart_in(sys_edge | st_q.sel_chg),
    .expired_out(pri_expired)
  );

  // ----------------------------------------------------------------
  // Watchdog oscillator watch: system clock edges with no wdt edge
  // ----------------------------------------------------------------
  // A very slow system clock makes this watch equally slow.
  cfm_watch #(
    .LIMIT(WDT_FAIL_EDGES)
  ) u_wdt_watch (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .run_in(wdt_run),
    .tick_in(sys_edge),
    .restart_in(wdt_edge | st_q.sel_chg),
    .expired_out(wdt_expired)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic pri_set;
  logic wdt_set;
  logic do_fallback;

  always_comb
  begin
    st_d = st_q;
    st_d.sel_chg = 1'b0;

    pri_set = pri_expired & pri_run;
    wdt_set = wdt_expired & wdt_run;

    // Only from normal running, with a live and distinct fallback source
    do_fallback = pri_set
                  & (st_q.mode == CFM_RUN)
                  & ctrl_in.wdt_osc_en
                  & (st_q.req_sel != `CFM_SRC_WDT);

    // Oscillator enable follows software only, never the selection
    st_d.stat.internal_precision_osc_en = ctrl_in.internal_precision_osc_en;

    // A select write ends any fallback and takes the new source
    if (ctrl_in.select_write)
    begin
      st_d.req_sel = ctrl_in.clock_source_select;
      st_d.mode = CFM_RUN;
      st_d.sel_chg = 1'b1;
    end
    else if (do_fallback)
      st_d.mode = CFM_FALLBACK;

    unique case (st_d.mode)
      CFM_RUN: st_d.stat.sys_clk_select = st_d.req_sel;
      CFM_FALLBACK: st_d.stat.sys_clk_select = `CFM_SRC_WDT;
    endcase
    st_d.stat.fallback_active = (st_d.mode == CFM_FALLBACK);

    // Pending flags: a new failure beats the acknowledge in the same cycle
    st_d.stat.primary_fail_pending = pri_set
                                     | (st_q.stat.primary_fail_pending
                                        & ~ack_in.primary_taken);
    st_d.stat.wdt_fail_pending = wdt_set
                                 | (st_q.stat.wdt_fail_pending
                                    & ~ack_in.wdt_taken);

    // Dead watchdog oscillator is remembered until reset
    st_d.stat.wdt_failed = st_q.stat.wdt_failed | wdt_set;

    st_d.stat.nmi = st_d.stat.primary_fail_pending
                    | st_d.stat.wdt_fail_pending;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      st_q <= '0;
      st_q.mode <= CFM_RUN;
      st_q.req_sel <= `CFM_RST_SEL;
      st_q.stat.sys_clk_select <= `CFM_RST_SEL;
      st_q.stat.internal_precision_osc_en <= `CFM_RST_IPO_EN;
    end
    else if (ce_in)
      st_q <= st_d;
  end

  assign status_out = st_q.stat;

endmodule : cfm_clock_failure_monitor

// File: rtl/cfm_edge_sync.sv
`timescale 1ns/1ps

module cfm_edge_sync
  import cfm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic async_in,
  output logic rise_out
);

  cfm_sync_state_t st_q;
  cfm_sync_state_t st_d;

  // ----------------------------------------------------------------
  // Three-stage capture, level accepted when stages two and three agree
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.rise = 1'b0;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.lvl = st_q.s3;
      st_d.rise = st_q.s3 & ~st_q.lvl;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      st_q <= '0;
    else if (ce_in)
      st_q <= st_d;
  end

  assign rise_out = st_q.rise;

endmodule : cfm_edge_sync

// File: rtl/cfm_map.svh
`ifndef CFM_MAP_SVH
`define CFM_MAP_SVH

// ----------------------------------------------------------------
// Clock source encodings (index into the oscillator input vector)
// ----------------------------------------------------------------
`define CFM_SRC_W 2
`define CFM_SRC_IPO 2'h0
`define CFM_SRC_XTAL 2'h1
`define CFM_SRC_WDT 2'h2
`define CFM_SRC_EXT 2'h3
`define CFM_NUM_SRC 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFM_RST_SEL `CFM_SRC_IPO
`define CFM_RST_IPO_EN 1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CFM_CLK_PERIOD_PS 5000
// Slowest primary clock still taken as alive: 1 kHz, i.e. 1 ms
`define CFM_PRI_FAIL_PERIOD_PS 1000000000
`define CFM_PRI_FAIL_CYCLES (`CFM_PRI_FAIL_PERIOD_PS / `CFM_CLK_PERIOD_PS)
`define CFM_WDT_FAIL_EDGES 8004

`endif

// File: rtl/cfm_pkg.sv
`include "cfm_map.svh"

package cfm_pkg;

  // ----------------------------------------------------------------
  // Software control bits
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`CFM_SRC_W-1:0] clock_source_select;
    logic select_write;
    logic primary_fail_detect_en;
    logic wdt_osc_fail_detect_en;
    logic wdt_osc_en;
    logic internal_precision_osc_en;
  } cfm_oscillator_control_t;

  typedef struct packed {
    logic primary_taken;
    logic wdt_taken;
  } cfm_ack_t;

  typedef struct packed {
    logic [`CFM_SRC_W-1:0] sys_clk_select;
    logic internal_precision_osc_en;
    logic fallback_active;
    logic primary_fail_pending;
    logic wdt_fail_pending;
    logic wdt_failed;
    logic nmi;
  } cfm_status_t;

  typedef enum logic {CFM_RUN, CFM_FALLBACK} cfm_mode_t;

  typedef struct packed {
    cfm_mode_t mode;
    logic [`CFM_SRC_W-1:0] req_sel;
    logic sel_chg;
    cfm_status_t stat;
  } cfm_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } cfm_sync_state_t;

endpackage : cfm_pkg

// File: rtl/cfm_watch.sv
`timescale 1ns/1ps
`include "cfm_map.svh"

module cfm_watch
  import cfm_pkg::*;
#(
  parameter int LIMIT = `CFM_WDT_FAIL_EDGES
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic restart_in,
  output logic expired_out
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic expired;
  } cfm_watch_state_t;

  cfm_watch_state_t st_q;
  cfm_watch_state_t st_d;

  // ----------------------------------------------------------------
  // Count ticks since the last sign of life
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.expired = 1'b0;
    if (!run_in || restart_in)
      st_d.cnt = '0;
    else if (tick_in)
    begin
      if (st_q.cnt == LAST)
      begin
        st_d.cnt = '0;
        st_d.expired = 1'b1;
      end
      else
        st_d.cnt = st_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      st_q <= '0;
    else if (ce_in)
      st_q <= st_d;
  end

  assign expired_out = st_q.expired;

endmodule : cfm_watch

// File: tb/cfm_monitor_checker.sv
`timescale 1ns/1ps
`include "cfm_map.svh"

module cfm_monitor_checker
  import cfm_pkg::*;
#(
  parameter int PRI_FAIL_CYCLES = 50,
  parameter int WDT_FAIL_EDGES = 16
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [`CFM_NUM_SRC-1:0] osc_in,
  input wire cfm_oscillator_control_t ctrl_in,
  input wire cfm_ack_t ack_in,
  input wire cfm_status_t status_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_reset_state: assert property ($rose(reset_n_in) |->
    status_out.internal_precision_osc_en && status_out.sys_clk_select == `CFM_SRC_IPO
    && !status_out.nmi && !status_out.fallback_active) else $error("status not at reset");
  a_ipo_follow: assert property (ce_in |=> status_out.internal_precision_osc_en ==
    $past(ctrl_in.internal_precision_osc_en)) else $error("ipo enable not followed");
  a_nmi_join: assert property (status_out.nmi ==
    (status_out.primary_fail_pending || status_out.wdt_fail_pending)) else $error("nmi wrong");
  a_fallback_wdt: assert property (status_out.fallback_active |->
    status_out.sys_clk_select == `CFM_SRC_WDT) else $error("fallback not on wdt osc");
  a_fallback_cause: assert property ($rose(status_out.fallback_active) |->
    $past(ctrl_in.wdt_osc_en) && $past(status_out.sys_clk_select) != `CFM_SRC_WDT
    && status_out.primary_fail_pending && !$past(status_out.wdt_failed))
    else $error("fallback without cause");
  a_wdt_keeps_clk: assert property ($rose(status_out.wdt_fail_pending)
    && !$past(ctrl_in.select_write) |-> $stable(status_out.sys_clk_select))
    else $error("wdt failure moved clock");
  a_no_pri_after: assert property (status_out.wdt_failed |=>
    !$rose(status_out.primary_fail_pending) && status_out.wdt_failed)
    else $error("primary failure after wdt failure");
  a_pending_hold: assert property (status_out.primary_fail_pending
    && !ack_in.primary_taken |=> status_out.primary_fail_pending) else $error("pending lost");
  a_select_take: assert property (ce_in && ctrl_in.select_write |=>
    status_out.sys_clk_select == $past(ctrl_in.clock_source_select)
    && !status_out.fallback_active) else $error("select not taken");
endmodule : cfm_monitor_checker

bind cfm_clock_failure_monitor cfm_monitor_checker #(.PRI_FAIL_CYCLES(PRI_FAIL_CYCLES),
  .WDT_FAIL_EDGES(WDT_FAIL_EDGES)) chk_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .ce_in(ce_in), .osc_in(osc_in), .ctrl_in(ctrl_in), .ack_in(ack_in), .status_out(status_out));

// File: tb/cfm_osc_model.sv
`timescale 1ns/1ps

module cfm_osc_model
#(
  parameter int HALF = 3
)
(
  input wire logic clk_in,
  input wire logic [3:0] run_in,
  output logic [3:0] osc_out
);
  int cnt = 0;
  initial osc_out = 4'h0;
  // A stopped source freezes at its last level, like a dead crystal
  always @(negedge clk_in)
  begin
    cnt = (cnt + 1) % HALF;
    if (cnt == 0)
      osc_out <= osc_out ^ run_in;
  end
endmodule : cfm_osc_model

// File: tb/tb.sv
`timescale 1ns/1ps
`include "cfm_map.svh"
`define CFM_CHECK(nm, exp, got) \
  begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module tb;
  import cfm_pkg::*;
  localparam int PRI = 50;
  localparam int WDT = 16;
  localparam int HALF = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] run = 4'hf;
  logic [3:0] osc;
  cfm_oscillator_control_t ctrl = 7'h01;
  cfm_ack_t ack = 2'h0;
  cfm_status_t st;
  int mismatches = 0;
  int total_checks = 0;
  int cnt;

  cfm_osc_model #(.HALF(HALF)) osc_u (.clk_in(clk), .run_in(run), .osc_out(osc));
  cfm_clock_failure_monitor #(.PRI_FAIL_CYCLES(PRI), .WDT_FAIL_EDGES(WDT)) dut_u (
    .clk_in(clk), .reset_n_in(rst_n), .ce_in(ce), .osc_in(osc),
    .ctrl_in(ctrl), .ack_in(ack), .status_out(st));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic wait_fail(input bit pri);
    cnt = 0;
    while ((pri ? st.primary_fail_pending : st.wdt_fail_pending) !== 1'b1 && cnt < 2000)
    begin
      @(negedge clk);
      cnt++;
    end
    `CFM_CHECK("failure seen", 1'b1, pri ? st.primary_fail_pending : st.wdt_fail_pending)
  endtask : wait_fail

  // Detectors go off before every switch, else a spurious failure may fire
  task automatic select_src(input logic [1:0] s);
    ctrl.primary_fail_detect_en = 1'b0;
    ctrl.wdt_osc_fail_detect_en = 1'b0;
    ctrl.clock_source_select = s;
    ctrl.select_write = 1'b1;
    @(negedge clk);
    ctrl.select_write = 1'b0;
    `CFM_CHECK("source", s, st.sys_clk_select)
    `CFM_CHECK("fallback", 1'b0, st.fallback_active)
  endtask : select_src

  task automatic ack_event(input bit pri);
    ack = pri ? 2'h2 : 2'h1;
    @(negedge clk);
    ack = 2'h0;
    @(negedge clk);
    `CFM_CHECK("pending", 1'b0, pri ? st.primary_fail_pending : st.wdt_fail_pending)
  endtask : ack_event

  task automatic t_reset;
    `CFM_CHECK("reset source", `CFM_SRC_IPO, st.sys_clk_select)
    `CFM_CHECK("reset ipo", 1'b1, st.internal_precision_osc_en)
    ctrl.internal_precision_osc_en = 1'b0;
    repeat (2) @(negedge clk);
    `CFM_CHECK("ipo off", 1'b0, st.internal_precision_osc_en)
    ctrl.internal_precision_osc_en = 1'b1;
  endtask : t_reset

  task automatic t_pri_fail(input bit wdt_on);
    select_src(`CFM_SRC_XTAL);
    `CFM_CHECK("ipo kept", 1'b1, st.internal_precision_osc_en)
    ctrl.wdt_osc_en = wdt_on;
    ctrl.primary_fail_detect_en = 1'b1;
    repeat (10) @(negedge clk);
    run[1] = 1'b0;
    wait_fail(1'b1);
    `CFM_CHECK("pri delay", 1'b1, cnt >= PRI - 2 * HALF - 2 && cnt <= PRI + 10)
    `CFM_CHECK("pri nmi", 1'b1, st.nmi)
    `CFM_CHECK("fallback", wdt_on, st.fallback_active)
    `CFM_CHECK("fb source", wdt_on ? `CFM_SRC_WDT : `CFM_SRC_XTAL, st.sys_clk_select)
    ack_event(1'b1);
    `CFM_CHECK("fb kept", wdt_on, st.fallback_active)
    run[1] = 1'b1;
  endtask : t_pri_fail

  task automatic t_wdt_src;
    select_src(`CFM_SRC_WDT);
    ctrl.wdt_osc_en = 1'b1;
    ctrl.primary_fail_detect_en = 1'b1;
    repeat (10) @(negedge clk);
    run[2] = 1'b0;
    wait_fail(1'b1);
    `CFM_CHECK("wdt src fb", 1'b0, st.fallback_active)
    `CFM_CHECK("wdt src", `CFM_SRC_WDT, st.sys_clk_select)
    ack_event(1'b1);
    run[2] = 1'b1;
  endtask : t_wdt_src

  // Enable low swallows a select write; stopped ext clock stays unflagged with detection off
  task automatic t_ext_freeze;
    ce = 1'b0;
    ctrl.clock_source_select = `CFM_SRC_EXT;
    ctrl.select_write = 1'b1;
    @(negedge clk);
    ctrl.select_write = 1'b0;
    repeat (2) @(negedge clk);
    ce = 1'b1;
    `CFM_CHECK("frozen source", `CFM_SRC_WDT, st.sys_clk_select)
    select_src(`CFM_SRC_EXT);
    ctrl.primary_fail_detect_en = 1'b0;
    run[3] = 1'b0;
    repeat (PRI + 40) @(negedge clk);
    `CFM_CHECK("ext unflagged", 1'b0, st.primary_fail_pending)
    run[3] = 1'b1;
  endtask : t_ext_freeze

  task automatic t_wdt_fail;
    select_src(`CFM_SRC_IPO);
    ctrl.wdt_osc_fail_detect_en = 1'b1;
    repeat (10) @(negedge clk);
    run[2] = 1'b0;
    wait_fail(1'b0);
    `CFM_CHECK("wdt delay", 1'b1, cnt >= (WDT - 2) * 2 * HALF && cnt <= (WDT + 1) * 2 * HALF + 10)
    `CFM_CHECK("wdt keeps src", `CFM_SRC_IPO, st.sys_clk_select)
    `CFM_CHECK("wdt nmi", 1'b1, st.nmi)
    ack_event(1'b0);
    `CFM_CHECK("wdt failed", 1'b1, st.wdt_failed)
    ctrl.primary_fail_detect_en = 1'b1;
    run[0] = 1'b0;
    repeat (PRI + 40) @(negedge clk);
    `CFM_CHECK("pri blind", 1'b0, st.primary_fail_pending)
  endtask : t_wdt_fail

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    $display("t_reset done");
    t_pri_fail(1'b1);
    $display("t_pri_fail fallback done");
    t_pri_fail(1'b0);
    $display("t_pri_fail no fallback done");
    t_wdt_src();
    $display("t_wdt_src done");
    t_ext_freeze();
    $display("t_ext_freeze done");
    t_wdt_fail();
    $display("t_wdt_fail done");
    print_verdict();
  end
endmodule : tb
